// File: hdl/pmcs_osc_sense.sv
/*
 Two-flop synchroniser with rising edge detect.
 Assumes the input is asynchronous to I_MCLK and, for a clock,
 well below half the I_MCLK rate.
*/
`timescale 1ns/1ps
`default_nettype none
module pmcs_osc_sense
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   // Raw level
   input  wire logic i_level,
   // Synchronised level and rise pulse
   output var  logic o_level,
   output var  logic o_rise
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // Two stages, then a history flop for the edge
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= i_level;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // Only the second stage and later are read
   assign o_level = sync_reg;
   assign o_rise  = sync_reg & ~last_reg;

endmodule
`default_nettype wire

// File: hdl/pmcs_pkg.sv
/*
 Constants for the power mode clock switcher: register map,
 field positions, reset values, source codes and switch counts.
 Assumes an APB master with 32-bit data and byte addresses.
*/
package pmcs_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] PMCS_OSC_CTRL_OFS = 8'h00;
   localparam logic [7:0] PMCS_SEC_TMR_OFS  = 8'h04;
   localparam logic [7:0] PMCS_PRI_CFG_OFS  = 8'h08;
   localparam logic [7:0] PMCS_STATUS_OFS   = 8'h0C;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int PMCS_IDLE_BIT     = 7;
   localparam int PMCS_FREQ_LSB     = 4;
   localparam int PMCS_PRI_RDY_BIT  = 3;
   localparam int PMCS_FAST_STB_BIT = 2;
   localparam int PMCS_SEC_ACT_BIT  = 6;
   localparam int PMCS_SEC_EN_BIT   = 3;
   localparam int PMCS_ST_CPU_BIT   = 2;
   localparam int PMCS_ST_PER_BIT   = 3;
   localparam int PMCS_ST_BUSY_BIT  = 4;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [2:0] PMCS_FREQ_RST    = 3'h4;
   localparam logic [3:0] PMCS_PRI_CFG_RST = 4'h2;

   // ------------------------------------------------------------
   // Source codes and primary configurations
   // ------------------------------------------------------------
   localparam logic [1:0] PMCS_SRC_PRI  = 2'h0;
   localparam logic [1:0] PMCS_SRC_SEC  = 2'h1;
   localparam logic [1:0] PMCS_SRC_INT  = 2'h2;
   localparam logic [1:0] PMCS_SRC_NONE = 2'h3;
   localparam logic [3:0] PMCS_CFG_XTAL_MAX = 4'h2;
   localparam logic [3:0] PMCS_CFG_INTERNAL = 4'h8;

   // ------------------------------------------------------------
   // Counts
   // ------------------------------------------------------------
   localparam int PMCS_OST_CYCLES = 1024;
   localparam int PMCS_OUT_EDGES  = 2;
   localparam int PMCS_IN_EDGES   = 3;

endpackage

// File: hdl/pmcs_top.sv
/*
 Power mode clock switcher: APB registers, run/idle/sleep
 sequencing, glitch-free source switching except the direct jump to internal at two-speed start-up, and status flags.
 Assumes oscillators arrive as raw pins and that the sleep
 and wake pulses come from logic on I_MCLK.
*/
`timescale 1ns/1ps
`default_nettype none
module pmcs_top
#(
   parameter int OST_CYCLES = pmcs_pkg::PMCS_OST_CYCLES
)
(
   // Clock and reset
   input  wire logic        I_MCLK,
   input  wire logic        I_RST_B,
   // APB slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output var  logic [31:0] O_PRDATA,
   output var  logic        O_PREADY,
   output var  logic        O_PSLVERR,
   // Core events
   input  wire logic        I_SLEEP_EXEC,
   input  wire logic        I_WAKE,
   // Oscillator pins and status pins
   input  wire logic        I_PRI_OSC,
   input  wire logic        I_SEC_OSC,
   input  wire logic        I_INT_OSC,
   input  wire logic        I_SEC_OSC_RUNNING,
   input  wire logic        I_FAST_OSC_STABLE,
   input  wire logic        I_TWO_SPEED_EN,
   // Clock control
   output var  logic [1:0]  O_CLK_SEL,
   output var  logic        O_CPU_CLK_EN,
   output var  logic        O_PERIPH_CLK_EN,
   output var  logic        O_PRI_OSC_EN
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   typedef enum logic [2:0] {ST_RUN, ST_WAIT, ST_OUT, ST_IN, ST_IDLE, ST_SLEEP} pmcs_state_t;

   // Elaboration check: the start-up counter is 16 bits wide
   if (OST_CYCLES < 1 || OST_CYCLES > 65535)
   begin
      $error("OST_CYCLES out of range");
   end

   pmcs_state_t state_reg;
   pmcs_state_t state_next;
   logic [1:0]  sel_reg;
   logic [1:0]  new_src_reg;
   logic [1:0]  cnt_reg;
   logic [1:0]  boot_reg;
   logic        idle_sel_reg;
   logic [2:0]  freq_reg;
   logic [1:0]  src_sel_reg;
   logic        sec_en_reg;
   logic [3:0]  pri_cfg_reg;
   logic        pri_rdy_reg;
   logic        fast_stb_reg;
   logic        sec_act_reg;
   logic [15:0] ost_cnt_reg;
   logic        ost_done_reg;
   logic [1:0]  target;
   logic        target_ready;
   logic        old_rise;
   logic        new_rise;
   logic        pri_rise;
   logic        sec_rise;
   logic        int_rise;
   logic        sec_running;
   logic        fast_stable;
   logic        two_speed;
   logic        wr_en;
   logic        rd_en;
   logic        boot_done;
   logic [31:0] rd_data;
   logic        addr_ok;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   pmcs_osc_sense u_pri (.i_clk(I_MCLK), .i_rst_b(I_RST_B), .i_level(I_PRI_OSC),
                         .o_level(), .o_rise(pri_rise));
   pmcs_osc_sense u_sec (.i_clk(I_MCLK), .i_rst_b(I_RST_B), .i_level(I_SEC_OSC),
                         .o_level(), .o_rise(sec_rise));
   pmcs_osc_sense u_int (.i_clk(I_MCLK), .i_rst_b(I_RST_B), .i_level(I_INT_OSC),
                         .o_level(), .o_rise(int_rise));
   pmcs_osc_sense u_srun (.i_clk(I_MCLK), .i_rst_b(I_RST_B), .i_level(I_SEC_OSC_RUNNING),
                          .o_level(sec_running), .o_rise());
   pmcs_osc_sense u_fstb (.i_clk(I_MCLK), .i_rst_b(I_RST_B), .i_level(I_FAST_OSC_STABLE),
                          .o_level(fast_stable), .o_rise());
   pmcs_osc_sense u_boot (.i_clk(I_MCLK), .i_rst_b(I_RST_B), .i_level(I_TWO_SPEED_EN),
                          .o_level(two_speed), .o_rise());

   // ------------------------------------------------------------
   // Source decode
   // ------------------------------------------------------------
   function automatic logic src_edge(input logic [1:0] src, input logic p, input logic s,
                                     input logic i);
      case (src)
         pmcs_pkg::PMCS_SRC_PRI: src_edge = p;
         pmcs_pkg::PMCS_SRC_SEC: src_edge = s;
         pmcs_pkg::PMCS_SRC_INT: src_edge = i;
         default:                src_edge = 1'b0;
      endcase
   endfunction

   // Select field decode and readiness of the wanted source
   always_comb
   begin
      target = src_sel_reg[1] ? pmcs_pkg::PMCS_SRC_INT : {1'b0, src_sel_reg[0]};
      case (new_src_reg)
         pmcs_pkg::PMCS_SRC_PRI: target_ready = ost_done_reg;
         pmcs_pkg::PMCS_SRC_SEC: target_ready = sec_running;
         default:                target_ready = 1'b1;
      endcase
      old_rise = src_edge(sel_reg, pri_rise, sec_rise, int_rise);
      new_rise = src_edge(new_src_reg, pri_rise, sec_rise, int_rise);
   end

   assign boot_done = (boot_reg == 2'h3);

   // ------------------------------------------------------------
   // Mode sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN:
         begin
            if (I_SLEEP_EXEC)
               state_next = idle_sel_reg ? ST_IDLE : ST_SLEEP;
            else if (boot_done && target != sel_reg)
            begin
               if (target == pmcs_pkg::PMCS_SRC_SEC && !sec_en_reg)
                  state_next = ST_RUN;
               else if (target == pmcs_pkg::PMCS_SRC_PRI && !ost_done_reg)
                  state_next = ST_WAIT;
               else
                  state_next = ST_OUT;
            end
         end
         ST_WAIT:
         begin
            if (target != new_src_reg)
               state_next = ST_RUN;
            else if (target_ready)
               state_next = ST_OUT;
         end
         ST_OUT:
         begin
            if (sel_reg == pmcs_pkg::PMCS_SRC_NONE ||
                (old_rise && cnt_reg == 2'(pmcs_pkg::PMCS_OUT_EDGES - 1)))
               state_next = ST_IN;
         end
         ST_IN:
         begin
            if (target_ready && new_rise && cnt_reg == 2'(pmcs_pkg::PMCS_IN_EDGES - 1))
               state_next = ST_RUN;
         end
         ST_IDLE:
         begin
            if (I_WAKE)
               state_next = ST_RUN;
         end
         ST_SLEEP:
         begin
            if (I_WAKE)
               state_next = ST_IN;
         end
         default: state_next = ST_RUN;
      endcase
   end

   // State, selected source and switch edge counter
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         state_reg   <= ST_RUN;
         sel_reg     <= pmcs_pkg::PMCS_SRC_PRI;
         new_src_reg <= pmcs_pkg::PMCS_SRC_PRI;
         cnt_reg     <= 2'h0;
         boot_reg    <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (!boot_done)
            boot_reg <= boot_reg + 2'h1;
         if (boot_reg == 2'h2 && two_speed)
         begin
            sel_reg     <= pmcs_pkg::PMCS_SRC_INT;
            new_src_reg <= pmcs_pkg::PMCS_SRC_INT;
         end
         if (state_reg == ST_RUN && state_next != ST_RUN && state_next != ST_IDLE)
            new_src_reg <= target;
         if (state_next == ST_SLEEP)
            sel_reg <= pmcs_pkg::PMCS_SRC_NONE;
         if (state_reg != state_next)
            cnt_reg <= 2'h0;
         else if ((state_reg == ST_OUT && old_rise) ||
                  (state_reg == ST_IN && new_rise && target_ready))
            cnt_reg <= cnt_reg + 2'h1;
         if (state_reg == ST_OUT && state_next == ST_IN)
            sel_reg <= pmcs_pkg::PMCS_SRC_NONE;
         if (state_reg == ST_IN && state_next == ST_RUN)
            sel_reg <= new_src_reg;
      end
   end

   // ------------------------------------------------------------
   // Primary start-up timer
   // ------------------------------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         ost_cnt_reg  <= 16'(OST_CYCLES);
         ost_done_reg <= 1'b1;
      end
      else if (!O_PRI_OSC_EN || (boot_reg == 2'h2 && two_speed))
      begin
         ost_cnt_reg  <= 16'h0000;
         ost_done_reg <= 1'b0;
      end
      else if (pri_cfg_reg > pmcs_pkg::PMCS_CFG_XTAL_MAX)
         ost_done_reg <= 1'b1;
      else if (!ost_done_reg && pri_rise)
      begin
         ost_cnt_reg  <= ost_cnt_reg + 16'h0001;
         ost_done_reg <= (ost_cnt_reg == 16'(OST_CYCLES - 1));
      end
   end

   // ------------------------------------------------------------
   // Clock control outputs
   // ------------------------------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         O_CLK_SEL       <= pmcs_pkg::PMCS_SRC_PRI;
         O_CPU_CLK_EN    <= 1'b1;
         O_PERIPH_CLK_EN <= 1'b1;
         O_PRI_OSC_EN    <= 1'b1;
      end
      else
      begin
         O_CLK_SEL       <= sel_reg;
         O_CPU_CLK_EN    <= sel_reg != pmcs_pkg::PMCS_SRC_NONE &&
                            state_reg != ST_IDLE && state_reg != ST_SLEEP;
         O_PERIPH_CLK_EN <= sel_reg != pmcs_pkg::PMCS_SRC_NONE &&
                            state_reg != ST_SLEEP;
         O_PRI_OSC_EN    <= state_reg != ST_SLEEP &&
                            (sel_reg == pmcs_pkg::PMCS_SRC_PRI ||
                             (state_reg != ST_RUN && state_reg != ST_IDLE &&
                              new_src_reg == pmcs_pkg::PMCS_SRC_PRI));
      end
   end

   // ------------------------------------------------------------
   // Clock status flags
   // ------------------------------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         pri_rdy_reg  <= 1'b1;
         fast_stb_reg <= 1'b0;
         sec_act_reg  <= 1'b0;
      end
      else
      begin
         pri_rdy_reg  <= sel_reg == pmcs_pkg::PMCS_SRC_PRI;
         sec_act_reg  <= sel_reg == pmcs_pkg::PMCS_SRC_SEC;
         fast_stb_reg <= fast_stable && freq_reg != 3'h0 &&
                         (sel_reg == pmcs_pkg::PMCS_SRC_INT ||
                          (sel_reg == pmcs_pkg::PMCS_SRC_PRI &&
                           pri_cfg_reg == pmcs_pkg::PMCS_CFG_INTERNAL));
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   assign wr_en = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
   assign rd_en = I_PSEL & ~I_PENABLE;

   // Read mux
   always_comb
   begin
      rd_data = 32'h0000_0000;
      addr_ok = 1'b1;
      case (I_PADDR)
         pmcs_pkg::PMCS_OSC_CTRL_OFS:
         begin
            rd_data[pmcs_pkg::PMCS_IDLE_BIT]     = idle_sel_reg;
            rd_data[pmcs_pkg::PMCS_FREQ_LSB+:3]  = freq_reg;
            rd_data[pmcs_pkg::PMCS_PRI_RDY_BIT]  = pri_rdy_reg;
            rd_data[pmcs_pkg::PMCS_FAST_STB_BIT] = fast_stb_reg;
            rd_data[1:0]                         = src_sel_reg;
         end
         pmcs_pkg::PMCS_SEC_TMR_OFS:
         begin
            rd_data[pmcs_pkg::PMCS_SEC_ACT_BIT] = sec_act_reg;
            rd_data[pmcs_pkg::PMCS_SEC_EN_BIT]  = sec_en_reg;
         end
         pmcs_pkg::PMCS_PRI_CFG_OFS: rd_data[3:0] = pri_cfg_reg;
         pmcs_pkg::PMCS_STATUS_OFS:
         begin
            rd_data[1:0]                        = sel_reg;
            rd_data[pmcs_pkg::PMCS_ST_CPU_BIT]  = O_CPU_CLK_EN;
            rd_data[pmcs_pkg::PMCS_ST_PER_BIT]  = O_PERIPH_CLK_EN;
            rd_data[pmcs_pkg::PMCS_ST_BUSY_BIT] = state_reg != ST_RUN;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // No wait state: answer prepared in setup, given in the first access cycle
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= 32'h0000_0000;
      end
      else
      begin
         O_PREADY  <= rd_en;
         O_PSLVERR <= rd_en & ~addr_ok;
         if (rd_en)
            O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rd_data;
      end
   end

   // Software fields; the sequencer never writes them
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         idle_sel_reg <= 1'b0;
         freq_reg     <= pmcs_pkg::PMCS_FREQ_RST;
         src_sel_reg  <= pmcs_pkg::PMCS_SRC_PRI;
         sec_en_reg   <= 1'b0;
         pri_cfg_reg  <= pmcs_pkg::PMCS_PRI_CFG_RST;
      end
      else if (wr_en)
      begin
         case (I_PADDR)
            pmcs_pkg::PMCS_OSC_CTRL_OFS:
            begin
               idle_sel_reg <= I_PWDATA[pmcs_pkg::PMCS_IDLE_BIT];
               freq_reg     <= I_PWDATA[pmcs_pkg::PMCS_FREQ_LSB+:3];
               src_sel_reg  <= I_PWDATA[1:0];
            end
            pmcs_pkg::PMCS_SEC_TMR_OFS: sec_en_reg <= I_PWDATA[pmcs_pkg::PMCS_SEC_EN_BIT];
            pmcs_pkg::PMCS_PRI_CFG_OFS: pri_cfg_reg <= I_PWDATA[3:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sleep_stop_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      state_reg == ST_RUN && I_SLEEP_EXEC && !idle_sel_reg |-> ##2 !O_CPU_CLK_EN && !O_PERIPH_CLK_EN)
      else $error("sleep left clocks running");
   idle_keep_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      state_reg == ST_RUN && I_SLEEP_EXEC && idle_sel_reg && sel_reg != pmcs_pkg::PMCS_SRC_NONE
      |-> ##2 !O_CPU_CLK_EN && O_PERIPH_CLK_EN)
      else $error("idle gating wrong");
   run_clocks_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      state_reg == ST_RUN && sel_reg != pmcs_pkg::PMCS_SRC_NONE |=> O_CPU_CLK_EN && O_PERIPH_CLK_EN)
      else $error("run state not clocking");
   switch_in_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      state_reg == ST_IN && state_next == ST_RUN |-> new_rise && cnt_reg == 2'h2)
      else $error("incoming edge count wrong");
   gate_gap_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      state_reg == ST_OUT && state_next == ST_IN |=> sel_reg == pmcs_pkg::PMCS_SRC_NONE ##1
      O_CLK_SEL == pmcs_pkg::PMCS_SRC_NONE && !O_CPU_CLK_EN)
      else $error("sources overlap");
   pri_flag_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      sel_reg == pmcs_pkg::PMCS_SRC_PRI |=> pri_rdy_reg && !sec_act_reg)
      else $error("primary flag wrong");
   sec_flag_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      $rose(sel_reg == pmcs_pkg::PMCS_SRC_SEC) |=> sec_act_reg && !pri_rdy_reg)
      else $error("secondary flag wrong");
   sec_refuse_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      state_reg == ST_RUN && boot_done && !I_SLEEP_EXEC && !sec_en_reg &&
      target == pmcs_pkg::PMCS_SRC_SEC |=> state_reg == ST_RUN && $stable(sel_reg))
      else $error("secondary entered while disabled");
   ost_wait_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      O_PRI_OSC_EN && pri_cfg_reg <= pmcs_pkg::PMCS_CFG_XTAL_MAX &&
      ost_cnt_reg < 16'(OST_CYCLES) |-> !ost_done_reg)
      else $error("primary ready too early");

endmodule
`default_nettype wire

// File: verification/pmcs_top_test.sv
/*
 Self-checking bench for the power mode clock switcher: APB register
 checks, source switches, idle, sleep and wake sequences.
 Assumes the design's APB answers in one access cycle and that the
 oscillator pins run well below a quarter of the bus clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmcs_top_test;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        mclk, rst_b, psel, penable, pwrite, sleep_exec, wake;
   logic        secondary_run_state, fast_stb, two_spd;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, cpu_en, per_en, pri_en;
   logic [1:0]  clk_sel;
   logic [4:0]  div_cnt;
   logic [3:0]  st;
   int          failures, cmp_count, cycles;

   // State of the clock outputs as one value
   assign st = {clk_sel, cpu_en, per_en};

   pmcs_top #(.OST_CYCLES(4)) pmcs_top_inst
   (
      .I_MCLK(mclk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SLEEP_EXEC(sleep_exec), .I_WAKE(wake),
      .I_PRI_OSC(div_cnt[2]), .I_SEC_OSC(div_cnt[4]), .I_INT_OSC(div_cnt[3]),
      .I_SEC_OSC_RUNNING(secondary_run_state), .I_FAST_OSC_STABLE(fast_stb), .I_TWO_SPEED_EN(two_spd),
      .O_CLK_SEL(clk_sel), .O_CPU_CLK_EN(cpu_en), .O_PERIPH_CLK_EN(per_en), .O_PRI_OSC_EN(pri_en)
   );

   // ------------------------------------------------------------
   // Clock, slow oscillators and timeout
   // ------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Oscillator pins come from a divider, all far below the bus rate
   always @(posedge mclk)
   begin
      div_cnt <= div_cnt + 5'h01;
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         failures = failures + 1;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; a read compares its data, both compare the error
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
      int n;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n = n + 1;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         failures = failures + 1;
         $display("[ERR] %0t pready %h exp %h", $time, pready, 1'b1);
      end
      chk({31'h0, pslverr}, {31'h0, e});
      if (!w)
         chk(prdata, d);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Waits a bounded time for a given output select
   task automatic wait_sel(input logic [1:0] s);
      int n;
      n = 0;
      while (clk_sel !== s && n < 3000)
      begin
         @(posedge mclk);
         n = n + 1;
      end
      chk({30'h0, clk_sel}, {30'h0, s});
   endtask

   // One-cycle pulse on a core event, then time for the outputs
   task automatic pulse(input logic slp);
      @(posedge mclk);
      if (slp)
         sleep_exec <= 1'b1;
      else
         wake <= 1'b1;
      @(posedge mclk);
      sleep_exec <= 1'b0;
      wake       <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {rst_b, psel, penable, pwrite, sleep_exec, wake, secondary_run_state, fast_stb} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      div_cnt = 5'h00;
      two_spd = 1'b0;
      failures = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({28'h0, st}, 32'h3);
      xfer(1'b0, 8'h00, 32'h48, 1'b0);
      xfer(1'b0, 8'h04, 32'h00, 1'b0);
      xfer(1'b0, 8'h08, 32'h02, 1'b0);
      xfer(1'b0, 8'h0C, 32'h0C, 1'b0);
      xfer(1'b0, 8'h10, 32'h00, 1'b1);
      // Secondary chosen while its enable is clear
      xfer(1'b1, 8'h00, 32'h41, 1'b0);
      repeat (60) @(posedge mclk);
      chk({28'h0, st}, 32'h3);
      xfer(1'b1, 8'h00, 32'h40, 1'b0);
      // Enabled but not yet oscillating, then started
      xfer(1'b1, 8'h04, 32'h08, 1'b0);
      xfer(1'b1, 8'h00, 32'h41, 1'b0);
      repeat (60) @(posedge mclk);
      chk({30'h0, clk_sel}, 32'h3);
      secondary_run_state <= 1'b1;
      wait_sel(2'h1);
      chk({28'h0, st}, 32'h7);
      chk({31'h0, pri_en}, 32'h0);
      xfer(1'b0, 8'h00, 32'h41, 1'b0);
      xfer(1'b0, 8'h04, 32'h48, 1'b0);
      // Back to primary: old clock kept while the start-up count runs
      xfer(1'b1, 8'h00, 32'h40, 1'b0);
      repeat (10) @(posedge mclk);
      chk({28'h0, st}, 32'h7);
      chk({31'h0, pri_en}, 32'h1);
      wait_sel(2'h0);
      xfer(1'b0, 8'h00, 32'h48, 1'b0);
      xfer(1'b0, 8'h04, 32'h08, 1'b0);
      // Idle keeps the peripherals clocked
      xfer(1'b1, 8'h00, 32'hC0, 1'b0);
      pulse(1'b1);
      chk({28'h0, st}, 32'h1);
      pulse(1'b0);
      chk({28'h0, st}, 32'h3);
      xfer(1'b0, 8'h00, 32'hC8, 1'b0);
      // Sleep stops everything and clears the flags
      xfer(1'b1, 8'h00, 32'h40, 1'b0);
      pulse(1'b1);
      chk({28'h0, st}, 32'hC);
      xfer(1'b0, 8'h00, 32'h40, 1'b0);
      pulse(1'b0);
      wait_sel(2'h0);
      repeat (3) @(posedge mclk);
      chk({28'h0, st}, 32'h3);
      xfer(1'b0, 8'h00, 32'h48, 1'b0);
      // Internal block through code 11
      fast_stb <= 1'b1;
      xfer(1'b1, 8'h00, 32'h73, 1'b0);
      wait_sel(2'h2);
      repeat (2) @(posedge mclk);
      xfer(1'b0, 8'h00, 32'h77, 1'b0);
      chk({31'h0, pri_en}, 32'h0);
      // Secondary already running before it is chosen
      xfer(1'b1, 8'h00, 32'h71, 1'b0);
      wait_sel(2'h1);
      xfer(1'b0, 8'h00, 32'h71, 1'b0);
      xfer(1'b0, 8'h04, 32'h48, 1'b0);
      chk({31'h0, pri_en}, 32'h0);
      // Second reset in mid-run with two-speed start-up
      two_spd <= 1'b1;
      rst_b   <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (6) @(posedge mclk);
      chk({28'h0, st}, 32'hB);
      xfer(1'b0, 8'h00, 32'h44, 1'b0);
      wait_sel(2'h0);
      xfer(1'b0, 8'h00, 32'h48, 1'b0);
      // Internal block as primary: both flags may stand
      xfer(1'b1, 8'h08, 32'h08, 1'b0);
      xfer(1'b0, 8'h00, 32'h4C, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
